/* design/mxb_consts.svh */
// Purpose: Constants for the multiplexed external bus pin block
// Assumes: Register index times four gives the AXI4-Lite byte address
// Notes:   Widths are fixed; timing counts are in aclk cycles
//
// What this block does
// - Mode pins are latched into the mode bits when reset is released.
// - Debug pin is pseudo open-drain, single wire, with pull-up present.
// - Port A lines not used by the bus are general-purpose I/O.
// - Port A drives address 15..8 while bus clock low, except tester mode.
// - Port A carries data 15..8 while bus clock high in wide-style accesses.
// - Narrow modes and wide byte accesses put alternate bytes on port A.
// - Data direction follows read/write: read external drives, write device.
// - Port B drives address 7..0 while bus clock low, except tester mode.
// - Port B carries data 7..0 while bus clock high in wide-style accesses.
// - Port B lines not used by the bus are general-purpose I/O.
// - In expanded modes only, no-access output marks free bus cycles.
// - Pipe status bits drive port E lines 6 and 5 only when enabled.
// - Clock test output only in modes with mode bit c low, enabled externally, pipe overrides.
// - Port E lines 7..5 are general-purpose I/O when not alternate.
// - Bus clock runs free or pulses once per access (twice for narrow word accesses), high phase stretched.
// - Low strobe is low when the low data byte moves, except in narrow byte accesses at odd addresses.
// - Single-chip modes have no bus; ports A and B are plain I/O.
`ifndef MXB_CONSTS_SVH
`define MXB_CONSTS_SVH

// ==========================================================
// Register indices
`define MXB_IDX_PORT_A_DATA 6'h00
`define MXB_IDX_PORT_B_DATA 6'h01
`define MXB_IDX_PORT_A_DIR  6'h02
`define MXB_IDX_PORT_B_DIR  6'h03
`define MXB_IDX_PORT_E_DATA 6'h08
`define MXB_IDX_PORT_E_DIR  6'h09
`define MXB_IDX_PORT_E_ASGN 6'h0A
`define MXB_IDX_MODE        6'h0B
`define MXB_IDX_ACC_ADDR    6'h10
`define MXB_IDX_ACC_WDATA   6'h11
`define MXB_IDX_ACC_CTRL    6'h12
`define MXB_IDX_ACC_STAT    6'h13
`define MXB_IDX_BUS_CFG     6'h14
`define MXB_IDX_TESTER      6'h15

// ==========================================================
// Field positions
`define MXB_ASGN_NO_ACC_EN 4
`define MXB_ASGN_PIPE_OE   5
`define MXB_MODE_VIS_ON    3
`define MXB_CTRL_GO       0
`define MXB_CTRL_READ     1
`define MXB_CTRL_BYTE     2
`define MXB_CTRL_FREE     3
`define MXB_CTRL_VIS      4
`define MXB_CTRL_FETCH    5
`define MXB_CFG_FREE_RUN  4
`define MXB_CFG_TAG_EN    5
`define MXB_CFG_BD_LOW    6

// ==========================================================
// Mode codes {c,b,a}
`define MXB_MODE_SPEC_SINGLE 3'h0
`define MXB_MODE_EMU_NARROW  3'h1
`define MXB_MODE_SPEC_TEST   3'h2
`define MXB_MODE_EMU_WIDE    3'h3
`define MXB_MODE_NORM_SINGLE 3'h4
`define MXB_MODE_NORM_NARROW 3'h5
`define MXB_MODE_SPEC_PERIPH 3'h6
`define MXB_MODE_NORM_WIDE   3'h7

// ==========================================================
// Timing and responses
`define MXB_ADDR_CYC  5'h02
`define MXB_DATA_CYC  5'h03
`define MXB_RESP_OKAY 2'h0
`define MXB_RESP_SLV  2'h2

`endif

/* design/mxb_pkg.sv */
// Purpose: Types for the multiplexed external bus pin block
// Assumes: Constants live in mxb_consts.svh
// Notes:   All block state is one packed struct
package mxb_pkg;

  // ==========================================================
  // Access sequencer states, Gray along idle-addr-data-done
  typedef enum logic [1:0]
  {
    MXB_IDLE = 2'h0,
    MXB_ADDR = 2'h1,
    MXB_DATA = 2'h3,
    MXB_DONE = 2'h2
  } mxb_state_t;

  // ==========================================================
  // Complete block state
  typedef struct packed
  {
    logic [7:0]  pa_s1;
    logic [7:0]  pa_s2;
    logic [7:0]  pb_s1;
    logic [7:0]  pb_s2;
    logic [2:0]  pe_s1;
    logic [2:0]  pe_s2;
    logic        bd_s1;
    logic        bd_s2;
    logic        mode_taken;
    logic [2:0]  mode;
    logic        vis_on;
    logic [7:0]  pa_dat;
    logic [7:0]  pb_dat;
    logic [7:0]  pa_dir;
    logic [7:0]  pb_dir;
    logic [2:0]  pe_dat;
    logic [2:0]  pe_dir;
    logic        pipe_oe;
    logic        no_acc_en;
    logic [3:0]  stretch;
    logic        free_run;
    logic        tag_en;
    logic        bd_low;
    logic [15:0] acc_addr;
    logic [15:0] acc_wdat;
    logic [15:0] acc_rdat;
    logic        acc_rw;
    logic        acc_byte;
    logic        acc_free;
    logic        acc_vis;
    logic        acc_fetch;
    logic        second;
    logic        busy;
    logic        tag_hi;
    mxb_state_t  state;
    logic [4:0]  cnt;
    logic        phase;
    logic        clk_tog;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  pa_o;
    logic [7:0]  pa_oe;
    logic [7:0]  pb_o;
    logic [7:0]  pb_oe;
    logic [2:0]  pe_o;
    logic [2:0]  pe_oe;
    logic        bclk;
    logic        rw;
    logic        strb_lo_n;
    logic        bd_oe;
  } mxb_state_s_t;

endpackage

/* design/mxb_top.sv */
// Purpose: Pin-level multiplexed address/data bus with GPIO fallback
// Assumes: Pins pass two flops; pull-up on debug pin is outside
// Notes:   Software starts each bus access through the access registers
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "mxb_consts.svh"
`default_nettype none

module mxb_top
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Core side
  input  wire logic        pipe_status_bit1,
  input  wire logic        pipe_status_bit0,
  input  wire logic        clock_test_enable,
  // Port A pins
  input  wire logic [7:0]  port_a_in,
  output logic [7:0]       port_a_out,
  output logic [7:0]       port_a_oe,
  // Port B pins
  input  wire logic [7:0]  port_b_in,
  output logic [7:0]       port_b_out,
  output logic [7:0]       port_b_oe,
  // Port E lines 7..5
  input  wire logic [2:0]  port_e_in,
  output logic [2:0]       port_e_out,
  output logic [2:0]       port_e_oe,
  // Bus control pins
  output logic             bus_timing_clock,
  output logic             read_write,
  output logic             low_byte_strobe_n,
  // Background debug pin
  input  wire logic        background_debug_in,
  output logic             background_debug_out,
  output logic             background_debug_oe
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] mxb_lanes(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_wide(input logic [2:0] m);
    return (m == `MXB_MODE_EMU_WIDE) || (m == `MXB_MODE_NORM_WIDE) ||
           (m == `MXB_MODE_SPEC_TEST);
  endfunction

  function automatic logic is_narrow(input logic [2:0] m);
    return (m == `MXB_MODE_EMU_NARROW) || (m == `MXB_MODE_NORM_NARROW);
  endfunction

  function automatic logic [7:0] gpio_rd(input logic [7:0] dat,
                                         input logic [7:0] dir,
                                         input logic [7:0] pin);
    return (dir & dat) | (~dir & pin);
  endfunction

  // ==========================================================
  // State
  mxb_pkg::mxb_state_s_t st;
  mxb_pkg::mxb_state_s_t next_st;

  logic        expanded;
  logic        periph;
  logic        one_phase;
  logic        bus_on;
  logic        wdrive;
  logic [15:0] cur_addr;
  logic [31:0] v;
  logic        go;

  always_comb
  begin
    next_st = st;
    v = 32'h0000_0000;
    go = 1'b0;
    expanded = st.mode_taken && (is_wide(st.mode) || is_narrow(st.mode));
    periph = st.mode_taken && (st.mode == `MXB_MODE_SPEC_PERIPH);
    // Visible internal access in emulation narrow goes out 16 bits wide
    one_phase = is_wide(st.mode) || (st.mode == `MXB_MODE_EMU_NARROW &&
                st.vis_on && st.acc_vis);
    bus_on = expanded && (st.state == mxb_pkg::MXB_ADDR ||
             st.state == mxb_pkg::MXB_DATA);
    cur_addr = st.second ? (st.acc_addr | 16'h0001) : st.acc_addr;

    // Pin synchronisers
    next_st.pa_s1 = port_a_in;
    next_st.pa_s2 = st.pa_s1;
    next_st.pb_s1 = port_b_in;
    next_st.pb_s2 = st.pb_s1;
    next_st.pe_s1 = port_e_in;
    next_st.pe_s2 = st.pe_s1;
    next_st.bd_s1 = background_debug_in;
    next_st.bd_s2 = st.bd_s1;
    next_st.clk_tog = ~st.clk_tog;

    // mode latch
    // First edge after release takes the synchronised mode pins
    if (!st.mode_taken)
    begin
      next_st.mode_taken = 1'b1;
      next_st.mode = {st.bd_s2, st.pe_s2[1], st.pe_s2[0]};
    end

    // ==========================================================
    // AXI4-Lite write channel
    next_st.awready = awvalid && wvalid && !st.awready && !st.bvalid;
    next_st.wready = awvalid && wvalid && !st.awready && !st.bvalid;
    if (st.bvalid && bready)
    begin
      next_st.bvalid = 1'b0;
    end
    if (st.awready)
    begin
      next_st.bvalid = 1'b1;
      next_st.bresp = `MXB_RESP_OKAY;
      case (awaddr[7:2])
        `MXB_IDX_PORT_A_DATA:
        begin
          v = mxb_lanes({24'h00_0000, st.pa_dat}, wdata, wstrb);
          next_st.pa_dat = v[7:0];
        end
        `MXB_IDX_PORT_B_DATA:
        begin
          v = mxb_lanes({24'h00_0000, st.pb_dat}, wdata, wstrb);
          next_st.pb_dat = v[7:0];
        end
        `MXB_IDX_PORT_A_DIR:
        begin
          v = mxb_lanes({24'h00_0000, st.pa_dir}, wdata, wstrb);
          next_st.pa_dir = v[7:0];
        end
        `MXB_IDX_PORT_B_DIR:
        begin
          v = mxb_lanes({24'h00_0000, st.pb_dir}, wdata, wstrb);
          next_st.pb_dir = v[7:0];
        end
        `MXB_IDX_PORT_E_DATA:
        begin
          v = mxb_lanes({24'h00_0000, st.pe_dat, 5'h00}, wdata, wstrb);
          next_st.pe_dat = v[7:5];
        end
        `MXB_IDX_PORT_E_DIR:
        begin
          v = mxb_lanes({24'h00_0000, st.pe_dir, 5'h00}, wdata, wstrb);
          next_st.pe_dir = v[7:5];
        end
        `MXB_IDX_PORT_E_ASGN:
        begin
          if (wstrb[0])
          begin
            next_st.pipe_oe = wdata[`MXB_ASGN_PIPE_OE];
            next_st.no_acc_en = wdata[`MXB_ASGN_NO_ACC_EN];
          end
        end
        `MXB_IDX_MODE:
        begin
          if (wstrb[0])
          begin
            next_st.vis_on = wdata[`MXB_MODE_VIS_ON];
          end
        end
        `MXB_IDX_ACC_ADDR:
        begin
          v = mxb_lanes({16'h0000, st.acc_addr}, wdata, wstrb);
          next_st.acc_addr = v[15:0];
        end
        `MXB_IDX_ACC_WDATA:
        begin
          v = mxb_lanes({16'h0000, st.acc_wdat}, wdata, wstrb);
          next_st.acc_wdat = v[15:0];
        end
        `MXB_IDX_ACC_CTRL:
        begin
          // A start while busy or outside expanded modes is dropped
          if (wstrb[0] && wdata[`MXB_CTRL_GO] && !st.busy && expanded)
          begin
            go = 1'b1;
            next_st.acc_rw = wdata[`MXB_CTRL_READ];
            next_st.acc_byte = wdata[`MXB_CTRL_BYTE];
            next_st.acc_free = wdata[`MXB_CTRL_FREE];
            next_st.acc_vis = wdata[`MXB_CTRL_VIS];
            next_st.acc_fetch = wdata[`MXB_CTRL_FETCH];
          end
        end
        `MXB_IDX_BUS_CFG:
        begin
          if (wstrb[0])
          begin
            next_st.stretch = wdata[3:0];
            next_st.free_run = wdata[`MXB_CFG_FREE_RUN];
            next_st.tag_en = wdata[`MXB_CFG_TAG_EN];
            next_st.bd_low = wdata[`MXB_CFG_BD_LOW];
          end
        end
        `MXB_IDX_ACC_STAT, `MXB_IDX_TESTER:
        begin
          next_st.bresp = `MXB_RESP_OKAY;
        end
        default:
        begin
          next_st.bresp = `MXB_RESP_SLV;
        end
      endcase
    end

    // ==========================================================
    // AXI4-Lite read channel
    next_st.arready = arvalid && !st.arready && !st.rvalid;
    if (st.rvalid && rready)
    begin
      next_st.rvalid = 1'b0;
    end
    if (st.arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `MXB_RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      case (araddr[7:2])
        `MXB_IDX_PORT_A_DATA: next_st.rdata[7:0] = gpio_rd(st.pa_dat, st.pa_dir, st.pa_s2);
        `MXB_IDX_PORT_B_DATA: next_st.rdata[7:0] = gpio_rd(st.pb_dat, st.pb_dir, st.pb_s2);
        `MXB_IDX_PORT_A_DIR:  next_st.rdata[7:0] = st.pa_dir;
        `MXB_IDX_PORT_B_DIR:  next_st.rdata[7:0] = st.pb_dir;
        `MXB_IDX_PORT_E_DATA:
          next_st.rdata[7:5] = (st.pe_dir & st.pe_dat) | (~st.pe_dir & st.pe_s2);
        `MXB_IDX_PORT_E_DIR:  next_st.rdata[7:5] = st.pe_dir;
        `MXB_IDX_PORT_E_ASGN:
        begin
          next_st.rdata[`MXB_ASGN_PIPE_OE] = st.pipe_oe;
          next_st.rdata[`MXB_ASGN_NO_ACC_EN] = st.no_acc_en;
        end
        `MXB_IDX_MODE:        next_st.rdata[7:0] = {st.mode, 1'b0, st.vis_on, 3'h0};
        `MXB_IDX_ACC_ADDR:    next_st.rdata[15:0] = st.acc_addr;
        `MXB_IDX_ACC_WDATA:   next_st.rdata[15:0] = st.acc_wdat;
        `MXB_IDX_ACC_CTRL:
          next_st.rdata[5:1] = {st.acc_fetch, st.acc_vis, st.acc_free, st.acc_byte,
                                st.acc_rw};
        `MXB_IDX_ACC_STAT:    next_st.rdata = {st.acc_rdat, 14'h0000, st.tag_hi, st.busy};
        `MXB_IDX_BUS_CFG:
          next_st.rdata[6:0] = {st.bd_low, st.tag_en, st.free_run, st.stretch};
        `MXB_IDX_TESTER:      next_st.rdata[15:0] = {st.pa_s2, st.pb_s2};
        default:              next_st.rresp = `MXB_RESP_SLV;
      endcase
    end

    // ==========================================================
    // Access sequencer
    case (st.state)
      mxb_pkg::MXB_IDLE:
      begin
        next_st.phase = st.free_run ? ~st.phase : 1'b0;
        if (go)
        begin
          next_st.busy = 1'b1;
          next_st.tag_hi = 1'b0;
          next_st.second = 1'b0;
          next_st.phase = 1'b0;
          next_st.cnt = `MXB_ADDR_CYC - 5'h01;
          next_st.state = mxb_pkg::MXB_ADDR;
        end
      end
      mxb_pkg::MXB_ADDR:
      begin
        next_st.phase = 1'b0;
        next_st.cnt = st.cnt - 5'h01;
        if (st.cnt == 5'h00)
        begin
          // high phase stretched for slow accesses
          next_st.cnt = `MXB_DATA_CYC - 5'h01 + {1'b0, st.stretch};
          next_st.phase = 1'b1;
          next_st.state = mxb_pkg::MXB_DATA;
        end
      end
      mxb_pkg::MXB_DATA:
      begin
        next_st.phase = 1'b1;
        next_st.cnt = st.cnt - 5'h01;
        if (st.cnt == 5'h00)
        begin
          next_st.phase = 1'b0;
          if (st.acc_rw)
          begin
            if (one_phase && !st.acc_byte)
            begin
              next_st.acc_rdat = {st.pa_s2, st.pb_s2};
            end
            else if (st.second || (one_phase && st.acc_addr[0]))
            begin
              next_st.acc_rdat[7:0] = st.pa_s2;
            end
            else
            begin
              next_st.acc_rdat[15:8] = st.pa_s2;
            end
          end
          // tag sampled at the falling bus clock
          if (st.tag_en && st.acc_fetch && !st.second && !st.bd_s2)
          begin
            next_st.tag_hi = 1'b1;
          end
          // narrow word access takes a second byte phase
          if (!one_phase && !st.acc_byte && !st.second)
          begin
            next_st.second = 1'b1;
            next_st.cnt = `MXB_ADDR_CYC - 5'h01;
            next_st.state = mxb_pkg::MXB_ADDR;
          end
          else
          begin
            next_st.state = mxb_pkg::MXB_DONE;
          end
        end
      end
      mxb_pkg::MXB_DONE:
      begin
        next_st.phase = 1'b0;
        next_st.busy = 1'b0;
        next_st.state = mxb_pkg::MXB_IDLE;
      end
      default:
      begin
        next_st.state = mxb_pkg::MXB_IDLE;
      end
    endcase

    // ==========================================================
    // Pin drive, registered one cycle after the state
    // port A idle lines are GPIO
    next_st.pa_o = st.pa_dat;
    next_st.pa_oe = st.pa_dir;
    // port B idle lines are GPIO
    next_st.pb_o = st.pb_dat;
    next_st.pb_oe = st.pb_dir;
    next_st.bclk = expanded && st.phase;
    next_st.rw = 1'b1;
    next_st.strb_lo_n = 1'b1;
    wdrive = !st.acc_rw && st.state == mxb_pkg::MXB_DATA;
    // tester drives the bus in peripheral mode
    if (periph)
    begin
      next_st.pa_oe = 8'h00;
      next_st.pb_oe = 8'h00;
    end
    else if (bus_on)
    begin
      next_st.rw = st.acc_rw;
      // strobe low on one-phase words, one-phase odd bytes and second narrow phases
      next_st.strb_lo_n = !((one_phase && (!st.acc_byte || st.acc_addr[0])) ||
                            st.second);
      if (st.state == mxb_pkg::MXB_ADDR)
      begin
        // high address while bus clock low
        next_st.pa_o = cur_addr[15:8];
        next_st.pa_oe = 8'hFF;
        // low address while bus clock low
        next_st.pb_o = cur_addr[7:0];
        next_st.pb_oe = 8'hFF;
      end
      else
      begin
        next_st.pa_oe = wdrive ? 8'hFF : 8'h00;
        if (one_phase && !st.acc_byte)
        begin
          // high data byte on port A
          next_st.pa_o = st.acc_wdat[15:8];
          // low data byte on port B
          next_st.pb_o = st.acc_wdat[7:0];
          next_st.pb_oe = wdrive ? 8'hFF : 8'h00;
        end
        else
        begin
          next_st.pa_o = (st.second || st.acc_addr[0]) ? st.acc_wdat[7:0] :
                         st.acc_wdat[15:8];
          next_st.pb_o = cur_addr[7:0];
          next_st.pb_oe = 8'hFF;
        end
      end
    end

    next_st.pe_o = st.pe_dat;
    next_st.pe_oe = st.pe_dir;
    // no-access marker only in expanded modes
    if (expanded && st.no_acc_en)
    begin
      next_st.pe_o[2] = st.busy ? st.acc_free : 1'b1;
      next_st.pe_oe[2] = 1'b1;
    end
    // pipe status on lines 6 and 5
    if (st.pipe_oe && st.mode_taken)
    begin
      next_st.pe_o[1:0] = {pipe_status_bit1, pipe_status_bit0};
      next_st.pe_oe[1:0] = 2'h3;
    end
    // clock test output, only in modes with mode bit c low
    else if (st.mode_taken && !st.mode[2] && clock_test_enable)
    begin
      next_st.pe_o[1] = st.clk_tog;
      next_st.pe_oe[1] = 1'b1;
    end
    // pseudo open-drain, only ever pulls low
    next_st.bd_oe = st.mode_taken && st.bd_low;

    // reset clears state but keeps synchronisers moving
    if (!aresetn)
    begin
      next_st = '0;
      next_st.pa_s1 = port_a_in;
      next_st.pa_s2 = st.pa_s1;
      next_st.pb_s1 = port_b_in;
      next_st.pb_s2 = st.pb_s1;
      next_st.pe_s1 = port_e_in;
      next_st.pe_s2 = st.pe_s1;
      next_st.bd_s1 = background_debug_in;
      next_st.bd_s2 = st.bd_s1;
      next_st.rw = 1'b1;
      next_st.strb_lo_n = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    st <= next_st;
  end

  // ==========================================================
  // Outputs
  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign port_a_out = st.pa_o;
  assign port_a_oe = st.pa_oe;
  assign port_b_out = st.pb_o;
  assign port_b_oe = st.pb_oe;
  assign port_e_out = st.pe_o;
  assign port_e_oe = st.pe_oe;
  assign bus_timing_clock = st.bclk;
  assign read_write = st.rw;
  assign low_byte_strobe_n = st.strb_lo_n;
  assign background_debug_out = 1'b0;
  assign background_debug_oe = st.bd_oe;

endmodule

`default_nettype wire

/* test/mxb_monitor.sv */
// Purpose: Port checks for mxb_top
// Assumes: Bus clock not free-running
// Notes:   Bound at foot
`timescale 1ns/1ps
`default_nettype none
module mxb_monitor
(
  // Watched ports
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [7:0] port_a_oe,
  input wire logic bus_timing_clock,
  input wire logic read_write,
  input wire logic low_byte_strobe_n,
  input wire logic background_debug_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // Write cycle, read release, debug pin and AXI responses
  sequence adr;
    (!bus_timing_clock && port_a_oe == 8'hFF) [*2];
  endsequence
  sequence dat;
    (bus_timing_clock && !read_write && port_a_oe == 8'hFF) [*3];
  endsequence
  AST_WR_ADR: assert property ($fell(read_write) |-> adr) else $error("addr phase");
  AST_WR_CYC: assert property
    ($fell(read_write) |-> adr ##1 dat) else $error("write cycle");
  AST_WR_DRV: assert property
    (bus_timing_clock && !read_write |-> port_a_oe == 8'hFF) else $error("write drive");
  AST_RD_OFF: assert property
    (bus_timing_clock && read_write && !low_byte_strobe_n |-> port_a_oe == 8'h00)
    else $error("read lines driven");
  AST_BD_LOW: assert property (background_debug_out == 1'b0) else $error("debug pin");
  AST_B_AFT: assert property (awready |=> bvalid) else $error("no bvalid");
  AST_B_HLD: assert property (bvalid && !bready |=> bvalid) else $error("bvalid lost");
  AST_R_AFT: assert property (arready |=> rvalid) else $error("no rvalid");
endmodule
bind mxb_top mxb_monitor mxb_monitor_i (.aclk, .aresetn, .awready, .bvalid, .bready, .arready,
  .rvalid, .port_a_oe, .bus_timing_clock, .read_write, .low_byte_strobe_n, .background_debug_out);
`default_nettype wire

/* test/mxb_ext_mem.sv */
// Purpose: Memory and pull-up beside mxb_top
// Assumes: Reads answered at once
// Notes:   Released lines show the inverse word outside read data phases
`timescale 1ns/1ps
`default_nettype none
module mxb_ext_mem
(
  // Device pins
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe,
  input wire logic [7:0] port_b_out,
  input wire logic [7:0] port_b_oe,
  input wire logic bus_timing_clock,
  input wire logic read_write,
  input wire logic background_debug_oe,
  input wire logic [15:0] rd_word,
  input wire logic tag_high_half_n,
  // Resolved levels
  output logic [7:0] port_a_in,
  output logic [7:0] port_b_in,
  output logic background_debug_in
);
  logic [15:0] drv;
  assign drv = (bus_timing_clock && read_write) ? rd_word : ~rd_word;
  assign port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & drv[15:8]);
  assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & drv[7:0]);
  assign background_debug_in = !background_debug_oe && tag_high_half_n;
endmodule
`default_nettype wire

/* test/tb_mxb_top.sv */
// Purpose: Self-checking bench for mxb_top
// Assumes: Mode pins pick normal wide, then peripheral
// Notes:   Stretch 4 slows data phase
`timescale 1ns/1ps
`default_nettype none
module tb_mxb_top;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, pipe_status_bit1 = 1'b0, pipe_status_bit0 = 1'b0;
  logic clock_test_enable = 1'b0, awready, wready, bvalid, arready, rvalid, read_write;
  logic bus_timing_clock, low_byte_strobe_n, background_debug_in, background_debug_out;
  logic background_debug_oe, tag_high_half_n = 1'b1;
  logic [1:0] bresp, rresp, r;
  logic [2:0] awprot = 3'h0, arprot = 3'h0, port_e_in = 3'h3, port_e_out, port_e_oe;
  logic [3:0] wstrb = 4'hF;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, port_a_in, port_a_out, port_a_oe;
  logic [7:0] port_b_in, port_b_out, port_b_oe;
  logic [15:0] rd_word = 16'h0000, rnd = 16'h7951, cap_a, cap_d;
  logic [31:0] wdata = 32'h0, rdata, v;
  int fails = 0, compares = 0;
  mxb_top mxb_top_i (.*);
  mxb_ext_mem mxb_ext_mem_i (.*);
  always #5 aclk = ~aclk;
  // ==========
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
    {awaddr, araddr, wdata} <= {a, a, d};
    {awvalid, wvalid, arvalid} <= {w, w, !w};
    do @(posedge aclk); while (awready !== 1'b1 && arready !== 1'b1);
    {awvalid, wvalid, arvalid, bready, rready} <= {3'h0, w, !w};
    do @(posedge aclk); while (bvalid !== 1'b1 && rvalid !== 1'b1);
    {v, r} = w ? {32'h0, bresp} : {rdata, rresp};
    {bready, rready} <= 2'h0;
  endtask
  task automatic acc(input logic [31:0] c);
    axi(1'b1, 8'h48, c);
    do axi(1'b0, 8'h4C, 32'h0); while (v[0] !== 1'b0);
  endtask
  // Address and data seen on write cycles
  always @(posedge aclk)
    if (!read_write)
      {cap_a, cap_d} <= bus_timing_clock ? {cap_a, port_a_out, port_b_out}
        : {port_a_out, port_b_out, cap_d};
  // ==========
  // Tests
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi(1'b0, 8'h2C, 32'h0);
    chk(v & 32'hE0, 32'hE0);
    $display("mode done");
    rnd = lfsr(rnd);
    axi(1'b1, 8'h08, {24'h0, rnd[15:8]});
    axi(1'b1, 8'h0C, {24'h0, rnd[7:0]});
    axi(1'b1, 8'h00, 32'hFF);
    axi(1'b1, 8'h04, 32'hFF);
    @(posedge aclk);
    chk({16'h0, port_a_oe, port_b_oe}, {16'h0, rnd});
    chk({16'h0, port_a_out & port_a_oe, port_b_out & port_b_oe}, {16'h0, rnd});
    $display("gpio done");
    axi(1'b1, 8'hFC, 32'h1);
    chk({30'h0, r}, 32'h2);
    axi(1'b0, 8'hFC, 32'h0);
    chk({30'h0, r}, 32'h2);
    $display("unmapped done");
    axi(1'b1, 8'h50, 32'h4);
    axi(1'b1, 8'h28, 32'h30);
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      {pipe_status_bit1, pipe_status_bit0} <= rnd[1:0];
      axi(1'b1, 8'h40, {16'h0, rnd});
      axi(1'b1, 8'h44, {16'h0, ~rnd});
      rd_word <= rnd ^ 16'h0F0F;
      acc(32'h1);
      chk({cap_a, cap_d}, {rnd, ~rnd});
      chk({26'h0, port_e_oe, port_e_out}, {26'h0, 3'h7, 1'b1, rnd[1:0]});
      acc(32'h3);
      chk({16'h0, v[31:16]}, {16'h0, rnd ^ 16'h0F0F});
    end
    $display("bus done");
    axi(1'b1, 8'h50, 32'h24);
    tag_high_half_n <= 1'b0;
    acc(32'h23);
    tag_high_half_n <= 1'b1;
    chk({31'h0, v[1]}, 32'h1);
    $display("tag done");
    aresetn <= 1'b0;
    port_e_in <= 3'h2;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi(1'b0, 8'h2C, 32'h0);
    chk(v & 32'hE0, 32'hC0);
    axi(1'b1, 8'h08, 32'hFF);
    axi(1'b0, 8'h54, 32'h0);
    chk({v[15:0], port_a_oe, port_b_oe}, {~rd_word, 16'h0});
    $display("periph done");
    end_sim();
  end
  initial
  begin
    #100us;
    fails++;
    $display("[ERR] %0t timeout", $time);
    end_sim();
  end
endmodule
`default_nettype wire
